// ==== src/decoder_status_ctrl.sv ====
// Decoder status byte two and analog input control registers five to seven, behind a serial host link.
// Assumes the status inputs come from decoder logic on mclk; the link pins and the indicator pin are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module decoder_status_ctrl
    import decoder_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output var logic sda_out,
    output var logic sda_oe,
    input wire decoder_status_t status_in,
    input wire logic clamp_mode_control,
    input wire logic source_switch_indicator_in,
    output var analog_ctrl_t ctrl_q,
    output var logic gain_loop_reset_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. Only the second and third stages feed any logic.

    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic sw_s1_q, sw_s2_q, sw_s3_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
            sw_s1_q <= 1'b0;
            sw_s2_q <= 1'b0;
            sw_s3_q <= 1'b0;
        end else begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
            sw_s1_q <= source_switch_indicator_in;
            sw_s2_q <= sw_s1_q;
            sw_s3_q <= sw_s2_q;
        end
    end

    wire scl_rise = scl_s2_q & ~scl_s3_q;
    wire scl_fall = ~scl_s2_q & scl_s3_q;
    wire start_cond = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
    wire stop_cond = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [7:0] status_q;
    logic [7:0] aic5_q;
    logic [7:0] ch3_low_q;
    logic [7:0] ch4_low_q;
    logic [7:0] sub_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    link_state_t state_q;

    wire byte_done = scl_fall & (bit_cnt_q == BITS_PER_BYTE);
    wire wr_stb = (state_q == ST_WDATA) & byte_done;
    wire wr_aic5 = wr_stb & (sub_q == AIC_FIVE_ADDR);
    wire wr_ch3 = wr_stb & (sub_q == CH3_GAIN_ADDR);
    wire wr_ch4 = wr_stb & (sub_q == CH4_GAIN_ADDR);
    wire addr_match = (shift_q[7:1] == DEV_ADDR);

    // The status address has no write path, so host writes there fall away.
    wire [7:0] rd_byte = (sub_q == STATUS_TWO_ADDR) ? status_q :
                         (sub_q == AIC_FIVE_ADDR) ? aic5_q :
                         (sub_q == CH3_GAIN_ADDR) ? ch3_low_q :
                         (sub_q == CH4_GAIN_ADDR) ? ch4_low_q : READ_NONE;

    wire [7:0] status_d = {
        status_in.interlaced,
        ~(status_in.h_loop_locked & status_in.v_loop_locked),
        status_in.field_60hz,
        1'b0,
        status_in.stripe_four_line,
        status_in.stripe_any,
        status_in.copy_protect,
        status_in.all_loops_locked
    };

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_q <= READ_NONE;
            aic5_q <= AIC5_RESET;
            ch3_low_q <= GAIN_LOW_RESET;
            ch4_low_q <= GAIN_LOW_RESET;
        end else begin
            status_q <= status_d;
            if (wr_aic5) begin
                aic5_q <= shift_q & AIC5_WRITE_MASK;
            end
            if (wr_ch3) begin
                ch3_low_q <= shift_q;
            end
            if (wr_ch4) begin
                ch4_low_q <= shift_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control outputs. They follow a write by one cycle so every output leaves a flop.

    wire sw_edge = sw_s2_q ^ sw_s3_q;
    wire ref_mode = aic5_q[AIC5_REF_BIT];

    analog_ctrl_t ctrl_d;

    always_comb begin
        ctrl_d.analog_out_select_msb = aic5_q[AIC5_AOSL_BIT];
        ctrl_d.adc_port_drive_enable = aic5_q[AIC5_PORT_BIT];
        ctrl_d.adc_clock_source_select = aic5_q[AIC5_CLK_BIT];
        ctrl_d.reference_mode_active = ref_mode;
        ctrl_d.clamp_active = ~ref_mode & clamp_mode_control;
        ctrl_d.ch3_gain = {aic5_q[AIC5_CH3_MSB_BIT], ch3_low_q};
        ctrl_d.ch4_gain = {aic5_q[AIC5_CH4_MSB_BIT], ch4_low_q};
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q <= '0;
            gain_loop_reset_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            gain_loop_reset_q <= sw_edge & aic5_q[AIC5_SWR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial link slave. Bits are sampled on the clock rise and driven after the fall.
    // The subaddress auto-increments after each data byte, in both directions.

    logic sda_oe_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            sub_q <= READ_NONE;
            shift_q <= READ_NONE;
            bit_cnt_q <= '0;
            sda_oe_q <= 1'b0;
        end else if (start_cond) begin
            state_q <= ST_ADDR;
            bit_cnt_q <= '0;
            sda_oe_q <= 1'b0;
        end else if (stop_cond) begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                ST_ADDR, ST_SUB, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s2_q};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_q <= '0;
                        if (state_q == ST_ADDR) begin
                            state_q <= addr_match ? ST_ADDR_ACK : ST_IDLE;
                            sda_oe_q <= addr_match;
                        end else begin
                            if (state_q == ST_SUB) begin
                                sub_q <= shift_q;
                            end else begin
                                sub_q <= sub_q + 8'h01;
                            end
                            state_q <= ST_WR_ACK;
                            sda_oe_q <= 1'b1;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (shift_q[0]) begin
                            shift_q <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                            state_q <= ST_RDATA;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q <= ST_SUB;
                        end
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        state_q <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_q <= '0;
                        sda_oe_q <= 1'b0;
                        sub_q <= sub_q + 8'h01;
                        state_q <= ST_RD_ACK;
                    end else if (scl_fall) begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        sda_oe_q <= ~shift_q[6];
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise && sda_s2_q) begin
                        state_q <= ST_IDLE;
                    end else if (scl_fall) begin
                        shift_q <= rd_byte;
                        sda_oe_q <= ~rd_byte[7];
                        state_q <= ST_RDATA;
                    end
                end
            endcase
        end
    end

    // Open-drain line: the module only ever pulls low.
    logic sda_out_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end

    assign sda_out = sda_out_q;
    assign sda_oe = sda_oe_q;

endmodule : decoder_status_ctrl

`default_nettype wire

// ==== src/decoder_regs_pkg.sv ====
// Constants and carrier types for the decoder status and analog input control register slice.
// Assumes one system clock and a serial two-wire host link that reaches the registers by subaddress.
//
// Notes on behaviour
// - Status bit 7 reads 1 for an interlaced source, 0 otherwise.
// - Status bit 6 reads 0 only when horizontal and vertical loops are both locked.
// - Status bit 5 reads 0 for 50 Hz fields and 1 for 60 Hz fields.
// - Status bit 3 reads 1 while the four-line stripe burst variant is detected.
// - Status bit 2 reads 1 while stripe burst of any type is detected.
// - Status bit 1 reads 1 while a copy-protected source is detected.
// - Status bit 0 reads 1 only when every internal loop is locked.
// - The status byte is read-only; host writes leave it unchanged.
// - Control five bit 6 low floats the converter output port, high drives it.
// - Control five bit 5 picks internal line-locked or external converter clock.
// - Control five bit 4 high selects reference mode, else clamping follows its own control.
// - With control five bit 2 set, any indicator edge resets the gain loop.
// - Channel 3 gain is nine bits: control five bit 0 over the channel 3 register.
// - Channel 4 gain is nine bits: control five bit 1 over the channel 4 register.
package decoder_regs_pkg;

    localparam logic [7:0] STATUS_TWO_ADDR = 8'h1F;
    localparam logic [7:0] AIC_FIVE_ADDR = 8'h23;
    localparam logic [7:0] CH3_GAIN_ADDR = 8'h24;
    localparam logic [7:0] CH4_GAIN_ADDR = 8'h25;

    localparam int AIC5_AOSL_BIT = 7;
    localparam int AIC5_PORT_BIT = 6;
    localparam int AIC5_CLK_BIT = 5;
    localparam int AIC5_REF_BIT = 4;
    localparam int AIC5_SWR_BIT = 2;
    localparam int AIC5_CH4_MSB_BIT = 1;
    localparam int AIC5_CH3_MSB_BIT = 0;
    localparam logic [7:0] AIC5_WRITE_MASK = 8'hF7;
    localparam logic [7:0] AIC5_RESET = 8'h00;
    localparam logic [7:0] GAIN_LOW_RESET = 8'h00;
    localparam logic [7:0] READ_NONE = 8'h00;

    // Arbitrary neutral seven-bit bus address.
    localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2A;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic interlaced;
        logic h_loop_locked;
        logic v_loop_locked;
        logic field_60hz;
        logic stripe_four_line;
        logic stripe_any;
        logic copy_protect;
        logic all_loops_locked;
    } decoder_status_t;

    typedef struct packed {
        logic analog_out_select_msb;
        logic adc_port_drive_enable;
        logic adc_clock_source_select;
        logic reference_mode_active;
        logic clamp_active;
        logic [8:0] ch3_gain;
        logic [8:0] ch4_gain;
    } analog_ctrl_t;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_ADDR_ACK = 8'h04,
        ST_SUB = 8'h08,
        ST_WR_ACK = 8'h10,
        ST_WDATA = 8'h20,
        ST_RDATA = 8'h40,
        ST_RD_ACK = 8'h80
    } link_state_t;

endpackage : decoder_regs_pkg

// ==== testbench/decoder_status_ctrl_asserts.sv ====
// Concurrent checks on the ports of the status and analog input control slice.
// Assumes one mclk domain with synchronous active low reset; bound to every instance below.
`timescale 1ns/1ps
`default_nettype none
module decoder_status_ctrl_asserts
    import decoder_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire decoder_status_t status_in,
    input wire logic clamp_mode_control,
    input wire logic source_switch_indicator_in,
    input wire analog_ctrl_t ctrl_q,
    input wire logic gain_loop_reset_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Six quiet samples cover the synchroniser and edge detector delay with margin.
    sequence pin_still;
        $stable(source_switch_indicator_in) [*6];
    endsequence
    sequence reset_left;
        $rose(rst_n);
    endsequence
    AST_RESET_CLEAR: assert property (reset_left |-> ctrl_q == '0 && !sda_oe && !gain_loop_reset_q)
        else $error("outputs not cleared after reset");
    AST_CLAMP_FOLLOW: assert property ($past(rst_n) |-> ctrl_q.clamp_active == (!ctrl_q.reference_mode_active && $past(clamp_mode_control)))
        else $error("clamp does not follow its control");
    AST_REF_OVERRIDES: assert property (ctrl_q.reference_mode_active |-> !ctrl_q.clamp_active)
        else $error("clamp active in reference mode");
    AST_GLR_CAUSE: assert property (pin_still |-> !gain_loop_reset_q)
        else $error("gain loop reset without indicator edge");
    AST_GLR_ONE_CYCLE: assert property (gain_loop_reset_q |=> !gain_loop_reset_q)
        else $error("gain loop reset longer than one cycle");
    // Control bits only move as a written byte completes, which is always in a clock low phase.
    AST_PORT_CHANGE: assert property ($changed(ctrl_q.adc_port_drive_enable) |-> !scl_in)
        else $error("port drive changed outside a write");
    AST_CLK_CHANGE: assert property ($changed(ctrl_q.adc_clock_source_select) |-> !scl_in)
        else $error("clock select changed outside a write");
    AST_GAIN_CHANGE: assert property ($changed({ctrl_q.ch3_gain, ctrl_q.ch4_gain}) |-> !scl_in)
        else $error("gain changed outside a write");
endmodule : decoder_status_ctrl_asserts
bind decoder_status_ctrl decoder_status_ctrl_asserts u_chk (.mclk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe,
    .status_in, .clamp_mode_control, .source_switch_indicator_in, .ctrl_q, .gain_loop_reset_q);
`default_nettype wire

// ==== testbench/i2c_host_model.sv ====
// Two-wire bus host driving the clock and pulling the data line low when sending 0.
// Assumes a pull-up on the data line; the clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    input wire logic mclk,
    input wire logic sda_line,
    output var logic scl,
    output var logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask : w
    task automatic start();
        sda_low = 1'b0;
        w(10);
        scl = 1'b1;
        w(10);
        sda_low = 1'b1;
        w(10);
        scl = 1'b0;
        w(2);
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        w(10);
        scl = 1'b1;
        w(10);
        sda_low = 1'b0;
        w(10);
    endtask : stop
    // Nine bits: a byte and the acknowledge slot; a 1 releases the line so the device may answer.
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sda_low = ~d[i];
            w(10);
            scl = 1'b1;
            w(10);
            q[i] = sda_line;
            scl = 1'b0;
            w(2);
        end
    endtask : xfer
endmodule : i2c_host_model
`default_nettype wire

// ==== testbench/tb_decoder_status_ctrl.sv ====
// Self-checking bench for the status and analog input control slice.
// Assumes the host model and the bound checker; inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module tb_decoder_status_ctrl;
    import decoder_regs_pkg::*;
    logic mclk, rst_n, scl, sda_low, sda_out, sda_oe, cm, ind, glr;
    wire logic sda_line;
    decoder_status_t st;
    analog_ctrl_t ctrl;
    int mismatches = 0;
    int n_tests = 0;
    int pulses = 0;
    logic [8:0] q;
    logic [7:0] rb;
    logic [15:0] rows [11] = '{16'h0040, 16'h6000, 16'h4040, 16'h2040, 16'h80C0, 16'h1060, 16'h0848, 16'h0444,
        16'h0242, 16'h0141, 16'hFFAF};
    assign sda_line = ~sda_low & ~(sda_oe & ~sda_out);
    i2c_host_model host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    decoder_status_ctrl uut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .status_in(st), .clamp_mode_control(cm), .source_switch_indicator_in(ind),
        .ctrl_q(ctrl), .gain_loop_reset_q(glr));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (glr === 1'b1) pulses++;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [22:0] exp, input logic [22:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic addr(input logic rdb);
        host.start();
        host.xfer({DEFAULT_DEV_ADDR, rdb, 1'b1}, q);
        chk("address ack", 23'h0, {22'h0, q[0]});
    endtask : addr
    task automatic wr(input logic [7:0] sub, input logic [23:0] d, input int n);
        addr(1'b0);
        host.xfer({sub, 1'b1}, q);
        for (int i = 0; i < n; i++) host.xfer({d[23 - 8 * i -: 8], 1'b1}, q);
        host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] sub, output logic [7:0] v);
        addr(1'b0);
        host.xfer({sub, 1'b1}, q);
        addr(1'b1);
        host.xfer(9'h1FF, q);
        v = q[8:1];
        host.stop();
    endtask : rd
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        chk("ctrl in reset", 23'h0, ctrl);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        rd(AIC_FIVE_ADDR, rb);
        chk("aic5 after reset", 23'h0, {15'h0, rb});
        $display("test reset done");
    endtask : do_reset
    task automatic edges(input logic [7:0] aic5, input int exp);
        wr(AIC_FIVE_ADDR, {aic5, 16'h0}, 1);
        pulses = 0;
        repeat (2) begin
            ind = ~ind;
            repeat (10) @(negedge mclk);
        end
        chk("gain loop resets", 23'(exp), 23'(pulses));
        $display("test indicator done");
    endtask : edges
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        st = '0;
        cm = 1'b0;
        ind = 1'b0;
        do_reset();
        foreach (rows[i]) begin
            st = rows[i][15:8];
            rd(STATUS_TWO_ADDR, rb);
            chk("status two", {15'h0, rows[i][7:0]}, {15'h0, rb});
        end
        $display("test status rows done");
        wr(STATUS_TWO_ADDR, 24'h000000, 1);
        rd(STATUS_TWO_ADDR, rb);
        chk("status read only", 23'h0000AF, {15'h0, rb});
        wr(AIC_FIVE_ADDR, 24'hFF9055, 3);
        chk("ctrl all set", {5'b11110, 9'h190, 9'h155}, ctrl);
        rd(AIC_FIVE_ADDR, rb);
        chk("aic5 unused bit", 23'h0000F7, {15'h0, rb});
        cm = 1'b1;
        wr(AIC_FIVE_ADDR, 24'h000000, 1);
        chk("ctrl clamp and 0 dB", {5'b00001, 9'h090, 9'h055}, ctrl);
        $display("test control done");
        // A second reset in mid-run must clear the control outputs; control five is read back after it, the gain registers are not.
        do_reset();
        edges(8'h04, 2);
        edges(8'h00, 0);
        summarize();
    end
    initial begin
        #1500000;
        mismatches++;
        $display("watchdog expired");
        summarize();
    end
endmodule : tb_decoder_status_ctrl
`default_nettype wire
